// [vpc_pkg.sv]
package vpc_pkg;

  // ----------------------------------------
  // serial framing
  // ----------------------------------------
  localparam logic [6:0] VPC_CHIP_ADDR = 7'h67;
  localparam int         VPC_RW_BIT    = 0;
  localparam int         VPC_IDX_HI    = 6;
  localparam int         VPC_IDX_LO    = 5;
  localparam int         VPC_DAT_HI    = 4;
  localparam int         VPC_DAT_LO    = 0;
  localparam logic [2:0] VPC_LAST_BIT  = 3'h7;

  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [1:0] VPC_IDX_POWER_CONTROL     = 2'h0;
  localparam logic [1:0] VPC_IDX_INPUT_PATH_CONFIG = 2'h1;
  localparam logic [1:0] VPC_IDX_INPUT_GAIN_CONFIG = 2'h2;
  localparam logic [1:0] VPC_IDX_EARPIECE_CONFIG   = 2'h3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [4:0] VPC_RST_POWER_CONTROL     = 5'h00;
  localparam logic [4:0] VPC_RST_INPUT_PATH_CONFIG = 5'h00;
  localparam logic [4:0] VPC_RST_INPUT_GAIN_CONFIG = 5'h00;
  localparam logic [4:0] VPC_RST_EARPIECE_CONFIG   = 5'h00;
  localparam logic [4:0] VPC_RST_PINS              = 5'h1f;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int VPC_PWR_RUN        = 0;
  localparam int VPC_PWR_SUPPLY_SEL = 1;
  localparam int VPC_PWR_EARPIECE   = 2;
  localparam int VPC_PATH_SIL1      = 0;
  localparam int VPC_PATH_SIL2      = 1;
  localparam int VPC_PATH_PERMIT    = 2;
  localparam int VPC_PATH_MODE_LO   = 3;
  localparam int VPC_PATH_MODE_HI   = 4;
  localparam int VPC_GAIN_PRE_HI    = 3;
  localparam int VPC_GAIN_PRE_LO    = 0;
  localparam int VPC_GAIN_POST      = 4;
  localparam int VPC_EP_IMP_LO      = 0;
  localparam int VPC_EP_IMP_HI      = 1;
  localparam int VPC_EP_SKIP        = 2;
  localparam int VPC_EP_LEVEL       = 3;
  localparam int VPC_EP_SILENCE     = 4;

  // ----------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------
  localparam int VPC_PIN_SCL     = 0;
  localparam int VPC_PIN_SDA     = 1;
  localparam int VPC_PIN_SUPPLY  = 2;
  localparam int VPC_PIN_IFRST   = 3;
  localparam int VPC_PIN_STANDBY = 4;
  localparam int VPC_PIN_COUNT   = 5;

  // ----------------------------------------
  // path modes and impedance codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    VPC_MODE_NOISE_CANCEL = 2'b00,
    VPC_MODE_MIC1_ONLY    = 2'b01,
    VPC_MODE_MIC2_ONLY    = 2'b10,
    VPC_MODE_AVERAGE      = 2'b11
  } vpc_mode_t;

  localparam logic [1:0] VPC_IMP_60K = 2'b00;
  localparam logic [1:0] VPC_IMP_9K  = 2'b01;

  // one-hot impedance select: bit0 60k, bit1 9k, bit2 6k
  localparam logic [2:0] VPC_ONEHOT_60K = 3'h1;
  localparam logic [2:0] VPC_ONEHOT_9K  = 3'h2;
  localparam logic [2:0] VPC_ONEHOT_6K  = 3'h4;

endpackage

// [vpc_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module vpc_sync #(
  parameter int         WIDTH   = 5,
  parameter logic [4:0] RST_VAL = 5'h1f
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  // settled levels
  output var  logic [WIDTH-1:0] level_out
);

  // ----------------------------------------
  // three stages, change taken when 2 and 3 agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          s1_q         <= RST_VAL[i];
          s2_q         <= RST_VAL[i];
          s3_q         <= RST_VAL[i];
          level_out[i] <= RST_VAL[i];
        end else begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            level_out[i] <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule // vpc_sync

`default_nettype wire

// [vpc_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module vpc_decode (
  // register contents
  input  wire logic [4:0] power_control,
  input  wire logic [4:0] input_path_config,
  input  wire logic [4:0] input_gain_config,
  input  wire logic [4:0] earpiece_config,
  // standby pin level
  input  wire logic       standby_n,
  // decoded controls
  output logic            run,
  output logic            earpiece_on,
  output logic            nc_enable,
  output logic            nc_bypass,
  output logic            mic1_route,
  output logic            mic2_route,
  output logic            mic_average,
  output logic            path1_silence,
  output logic            path2_silence,
  output logic [3:0]      preamp_gain,
  output logic            postamp_12db,
  output logic            output_lowpass_node_en,
  output logic            speaker_silence,
  output logic            level_limit_high,
  output logic            limiter_enable,
  output logic            enhancer_skip,
  output logic            earpiece_fixed_0db,
  output logic [2:0]      earpiece_impedance_sel
);

  vpc_pkg::vpc_mode_t mode;

  always_comb begin
    mode = vpc_pkg::vpc_mode_t'(input_path_config[vpc_pkg::VPC_PATH_MODE_HI:
                                                   vpc_pkg::VPC_PATH_MODE_LO]);
    // run bit and standby pin both gate everything except level_limit_high and earpiece_impedance_sel
    run = power_control[vpc_pkg::VPC_PWR_RUN] & standby_n;
    earpiece_on = run & power_control[vpc_pkg::VPC_PWR_EARPIECE];
    // silence bits only act under the permit bit
    path1_silence = run & input_path_config[vpc_pkg::VPC_PATH_PERMIT] &
                    input_path_config[vpc_pkg::VPC_PATH_SIL1];
    path2_silence = run & input_path_config[vpc_pkg::VPC_PATH_PERMIT] &
                    input_path_config[vpc_pkg::VPC_PATH_SIL2];
    nc_bypass   = run & (mode != vpc_pkg::VPC_MODE_NOISE_CANCEL);
    mic1_route  = run & (mode != vpc_pkg::VPC_MODE_MIC2_ONLY);
    mic2_route  = run & (mode != vpc_pkg::VPC_MODE_MIC1_ONLY);
    mic_average = run & (mode == vpc_pkg::VPC_MODE_AVERAGE);
    // a muted path kills noise cancelling
    nc_enable = run & (mode == vpc_pkg::VPC_MODE_NOISE_CANCEL) &
                ~path1_silence & ~path2_silence;
    preamp_gain  = run ? input_gain_config[vpc_pkg::VPC_GAIN_PRE_HI:
                                           vpc_pkg::VPC_GAIN_PRE_LO] : 4'h0;
    postamp_12db = run & input_gain_config[vpc_pkg::VPC_GAIN_POST];
    output_lowpass_node_en = run & (mode == vpc_pkg::VPC_MODE_NOISE_CANCEL);
    speaker_silence    = run & earpiece_config[vpc_pkg::VPC_EP_SILENCE];
    enhancer_skip      = run & earpiece_config[vpc_pkg::VPC_EP_SKIP];
    earpiece_fixed_0db = enhancer_skip;
    level_limit_high   = earpiece_config[vpc_pkg::VPC_EP_LEVEL];
    limiter_enable     = earpiece_on & ~enhancer_skip;
    case (earpiece_config[vpc_pkg::VPC_EP_IMP_HI:vpc_pkg::VPC_EP_IMP_LO])
      vpc_pkg::VPC_IMP_60K: earpiece_impedance_sel = vpc_pkg::VPC_ONEHOT_60K;
      vpc_pkg::VPC_IMP_9K:  earpiece_impedance_sel = vpc_pkg::VPC_ONEHOT_9K;
      default:              earpiece_impedance_sel = vpc_pkg::VPC_ONEHOT_6K;
    endcase
  end

endmodule // vpc_decode

`default_nettype wire

// [vpc_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module vpc_regs (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // serial control bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // supply and control pins
  input  wire logic       supply_ok_in,
  input  wire logic       iface_reset_n_in,
  input  wire logic       standby_n_in,
  // power and earpiece enable
  output logic            device_run,
  output logic            earpiece_on,
  output logic            supply_drop_reset_sel,
  // microphone path
  output logic            nc_enable,
  output logic            nc_bypass,
  output logic            mic1_route,
  output logic            mic2_route,
  output logic            mic_average,
  output logic            path1_silence,
  output logic            path2_silence,
  output logic            output_lowpass_node_en,
  // gain
  output logic [3:0]      preamp_gain,
  output logic            postamp_12db,
  // earpiece
  output logic            speaker_silence,
  output logic            level_limit_high,
  output logic            limiter_enable,
  output logic            enhancer_skip,
  output logic            earpiece_fixed_0db,
  output logic [2:0]      earpiece_impedance_sel
);

  // ----------------------------------------
  // state encoding
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_DATA     = 3'b011,
    ST_DATA_ACK = 3'b100,
    ST_SKIP     = 3'b101
  } vpc_bus_state_t;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [vpc_pkg::VPC_PIN_COUNT-1:0] pins_raw;
  logic [vpc_pkg::VPC_PIN_COUNT-1:0] pins_lvl;
  logic           scl_s;
  logic           sda_s;
  logic           supply_ok_s;
  logic           iface_reset_n_s;
  logic           standby_n_s;
  logic           scl_p_q;
  logic           sda_p_q;
  logic           scl_rise;
  logic           scl_fall;
  logic           bus_start;
  logic           bus_stop;
  vpc_bus_state_t state_q;
  vpc_bus_state_t state_d;
  logic [7:0]     shift_q;
  logic [2:0]     bit_cnt_q;
  logic           byte_full_q;
  logic           addr_hit;
  logic           commit;
  logic           supply_drop;
  logic [4:0]     power_control_q;
  logic [4:0]     input_path_config_q;
  logic [4:0]     input_gain_config_q;
  logic [4:0]     earpiece_config_q;
  logic           dec_run;
  logic           dec_earpiece_on;
  logic           dec_nc_enable;
  logic           dec_nc_bypass;
  logic           dec_mic1_route;
  logic           dec_mic2_route;
  logic           dec_mic_average;
  logic           dec_path1_silence;
  logic           dec_path2_silence;
  logic [3:0]     dec_preamp_gain;
  logic           dec_postamp_12db;
  logic           dec_lowpass_en;
  logic           dec_speaker_silence;
  logic           dec_level_limit_high;
  logic           dec_limiter_enable;
  logic           dec_enhancer_skip;
  logic           dec_fixed_0db;
  logic [2:0]     dec_impedance_sel;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_comb begin
    pins_raw                            = '0;
    pins_raw[vpc_pkg::VPC_PIN_SCL]      = scl_in;
    pins_raw[vpc_pkg::VPC_PIN_SDA]      = sda_in;
    pins_raw[vpc_pkg::VPC_PIN_SUPPLY]   = supply_ok_in;
    pins_raw[vpc_pkg::VPC_PIN_IFRST]    = iface_reset_n_in;
    pins_raw[vpc_pkg::VPC_PIN_STANDBY]  = standby_n_in;
  end

  vpc_sync #(
    .WIDTH   (vpc_pkg::VPC_PIN_COUNT),
    .RST_VAL (vpc_pkg::VPC_RST_PINS)
  ) u_sync (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pin_in    (pins_raw),
    .level_out (pins_lvl)
  );

  assign scl_s           = pins_lvl[vpc_pkg::VPC_PIN_SCL];
  assign sda_s           = pins_lvl[vpc_pkg::VPC_PIN_SDA];
  assign supply_ok_s     = pins_lvl[vpc_pkg::VPC_PIN_SUPPLY];
  assign iface_reset_n_s = pins_lvl[vpc_pkg::VPC_PIN_IFRST];
  assign standby_n_s     = pins_lvl[vpc_pkg::VPC_PIN_STANDBY];

  // ----------------------------------------
  // bus edge and condition detect
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // only a write to our address is acknowledged
  assign addr_hit = (shift_q[7:1] == vpc_pkg::VPC_CHIP_ADDR) &
                    ~shift_q[vpc_pkg::VPC_RW_BIT];
  assign commit   = (state_q == ST_DATA) & scl_fall & byte_full_q;

  // ----------------------------------------
  // bus state machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_IDLE;
      end
      ST_ADDR: begin
        if (scl_fall && byte_full_q) begin
          state_d = addr_hit ? ST_ADDR_ACK : ST_SKIP;
        end
      end
      ST_ADDR_ACK, ST_DATA_ACK: begin
        if (scl_fall) begin
          state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (commit) begin
          state_d = ST_DATA_ACK;
        end
      end
      ST_SKIP: begin
        state_d = ST_SKIP;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (bus_start) begin
      state_d = ST_ADDR;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // bit shifter
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shift_q     <= 8'h00;
      bit_cnt_q   <= 3'h0;
      byte_full_q <= 1'b0;
    end else if (bus_start || state_d != state_q) begin
      bit_cnt_q   <= 3'h0;
      byte_full_q <= 1'b0;
    end else if (scl_rise && (state_q == ST_ADDR || state_q == ST_DATA)) begin
      shift_q     <= {shift_q[6:0], sda_s};
      bit_cnt_q   <= bit_cnt_q + 3'h1;
      byte_full_q <= (bit_cnt_q == vpc_pkg::VPC_LAST_BIT);
    end
  end

  // ----------------------------------------
  // acknowledge driver, never read data
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= (state_d == ST_ADDR_ACK) || (state_d == ST_DATA_ACK);
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  assign supply_drop = ~power_control_q[vpc_pkg::VPC_PWR_SUPPLY_SEL] &
                       ~supply_ok_s;

  always_ff @(posedge clk_sys) begin
    if (!resetn || supply_drop) begin
      power_control_q     <= vpc_pkg::VPC_RST_POWER_CONTROL;
      input_path_config_q <= vpc_pkg::VPC_RST_INPUT_PATH_CONFIG;
      input_gain_config_q <= vpc_pkg::VPC_RST_INPUT_GAIN_CONFIG;
      earpiece_config_q   <= vpc_pkg::VPC_RST_EARPIECE_CONFIG;
    end else begin
      if (commit) begin
        case (shift_q[vpc_pkg::VPC_IDX_HI:vpc_pkg::VPC_IDX_LO])
          vpc_pkg::VPC_IDX_POWER_CONTROL:
            power_control_q <= shift_q[vpc_pkg::VPC_DAT_HI:vpc_pkg::VPC_DAT_LO];
          vpc_pkg::VPC_IDX_INPUT_PATH_CONFIG:
            input_path_config_q <= shift_q[vpc_pkg::VPC_DAT_HI:vpc_pkg::VPC_DAT_LO];
          vpc_pkg::VPC_IDX_INPUT_GAIN_CONFIG:
            input_gain_config_q <= shift_q[vpc_pkg::VPC_DAT_HI:vpc_pkg::VPC_DAT_LO];
          default:
            earpiece_config_q <= shift_q[vpc_pkg::VPC_DAT_HI:vpc_pkg::VPC_DAT_LO];
        endcase
      end
      // reset pin holds run bit clear, beats a write
      if (!iface_reset_n_s) begin
        power_control_q[vpc_pkg::VPC_PWR_RUN] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  vpc_decode u_decode (
    .power_control          (power_control_q),
    .input_path_config      (input_path_config_q),
    .input_gain_config      (input_gain_config_q),
    .earpiece_config        (earpiece_config_q),
    .standby_n              (standby_n_s),
    .run                    (dec_run),
    .earpiece_on            (dec_earpiece_on),
    .nc_enable              (dec_nc_enable),
    .nc_bypass              (dec_nc_bypass),
    .mic1_route             (dec_mic1_route),
    .mic2_route             (dec_mic2_route),
    .mic_average            (dec_mic_average),
    .path1_silence          (dec_path1_silence),
    .path2_silence          (dec_path2_silence),
    .preamp_gain            (dec_preamp_gain),
    .postamp_12db           (dec_postamp_12db),
    .output_lowpass_node_en (dec_lowpass_en),
    .speaker_silence        (dec_speaker_silence),
    .level_limit_high       (dec_level_limit_high),
    .limiter_enable         (dec_limiter_enable),
    .enhancer_skip          (dec_enhancer_skip),
    .earpiece_fixed_0db     (dec_fixed_0db),
    .earpiece_impedance_sel (dec_impedance_sel)
  );

  // ----------------------------------------
  // registered outputs, all move together
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      device_run             <= 1'b0;
      earpiece_on            <= 1'b0;
      supply_drop_reset_sel  <= 1'b0;
      nc_enable              <= 1'b0;
      nc_bypass              <= 1'b0;
      mic1_route             <= 1'b0;
      mic2_route             <= 1'b0;
      mic_average            <= 1'b0;
      path1_silence          <= 1'b0;
      path2_silence          <= 1'b0;
      output_lowpass_node_en <= 1'b0;
      preamp_gain            <= 4'h0;
      postamp_12db           <= 1'b0;
      speaker_silence        <= 1'b0;
      level_limit_high       <= 1'b0;
      limiter_enable         <= 1'b0;
      enhancer_skip          <= 1'b0;
      earpiece_fixed_0db     <= 1'b0;
      earpiece_impedance_sel <= vpc_pkg::VPC_ONEHOT_60K;
    end else begin
      device_run             <= dec_run;
      earpiece_on            <= dec_earpiece_on;
      supply_drop_reset_sel  <= power_control_q[vpc_pkg::VPC_PWR_SUPPLY_SEL];
      nc_enable              <= dec_nc_enable;
      nc_bypass              <= dec_nc_bypass;
      mic1_route             <= dec_mic1_route;
      mic2_route             <= dec_mic2_route;
      mic_average            <= dec_mic_average;
      path1_silence          <= dec_path1_silence;
      path2_silence          <= dec_path2_silence;
      output_lowpass_node_en <= dec_lowpass_en;
      preamp_gain            <= dec_preamp_gain;
      postamp_12db           <= dec_postamp_12db;
      speaker_silence        <= dec_speaker_silence;
      level_limit_high       <= dec_level_limit_high;
      limiter_enable         <= dec_limiter_enable;
      enhancer_skip          <= dec_enhancer_skip;
      earpiece_fixed_0db     <= dec_fixed_0db;
      earpiece_impedance_sel <= dec_impedance_sel;
    end
  end

endmodule // vpc_regs

`default_nettype wire

// [vpc_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module vpc_regs_sva (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // pins
  input wire logic       standby_n_in,
  input wire logic       iface_reset_n_in,
  input wire logic       sda_out,
  input wire logic       scl_in,
  input wire logic       sda_oe,
  // controls
  input wire logic       device_run,
  input wire logic       earpiece_on,
  input wire logic       nc_enable,
  input wire logic       nc_bypass,
  input wire logic       mic1_route,
  input wire logic       mic2_route,
  input wire logic       mic_average,
  input wire logic       path1_silence,
  input wire logic       output_lowpass_node_en,
  input wire logic       limiter_enable,
  input wire logic       enhancer_skip,
  input wire logic       earpiece_fixed_0db,
  input wire logic [2:0] earpiece_impedance_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_stby_low; !standby_n_in [*7]; endsequence
  sequence s_ifr_low; !iface_reset_n_in [*7]; endsequence
  property p_no_read; sda_out == 1'h0; endproperty
  property p_stby; s_stby_low |=> !device_run && !earpiece_on; endproperty
  property p_ifrst; s_ifr_low |=> !device_run; endproperty
  property p_off; !device_run |-> !earpiece_on && !nc_enable && !mic1_route; endproperty
  property p_nc; nc_enable |-> !nc_bypass && !path1_silence && mic1_route && mic2_route;
  endproperty
  property p_single; mic1_route ^ mic2_route |-> nc_bypass && !nc_enable && !mic_average;
  endproperty
  property p_avg; mic_average |-> mic1_route && mic2_route && nc_bypass; endproperty
  property p_lpf; output_lowpass_node_en == (mic1_route && mic2_route && !nc_bypass);
  endproperty
  property p_skip; earpiece_fixed_0db == enhancer_skip && !(enhancer_skip && limiter_enable);
  endproperty
  property p_imp; $onehot(earpiece_impedance_sel); endproperty
  // acknowledge pull only moves while the bus clock is low
  property p_ack_slot; $changed(sda_oe) |-> !scl_in; endproperty
  a_no_read: assert property (p_no_read)
    else $error("data line driven");
  a_stby: assert property (p_stby)
    else $error("active with standby low");
  a_ifrst: assert property (p_ifrst)
    else $error("active with interface reset low");
  a_off: assert property (p_off)
    else $error("enable while shut down");
  a_nc: assert property (p_nc)
    else $error("cancelling with muted path");
  a_single: assert property (p_single)
    else $error("single path not bypassed");
  a_avg: assert property (p_avg)
    else $error("average mode wrong");
  a_lpf: assert property (p_lpf)
    else $error("lowpass outside cancel mode");
  a_skip: assert property (p_skip)
    else $error("enhancer skip wrong");
  a_imp: assert property (p_imp)
    else $error("impedance not one-hot");
  a_ack_slot: assert property (p_ack_slot)
    else $error("acknowledge moved while clock high");
endmodule // vpc_regs_sva
bind vpc_regs vpc_regs_sva chk_i (.clk_sys, .resetn, .standby_n_in, .iface_reset_n_in,
  .sda_out, .scl_in, .sda_oe, .device_run, .earpiece_on, .nc_enable, .nc_bypass,
  .mic1_route, .mic2_route,
  .mic_average, .path1_silence, .output_lowpass_node_en, .limiter_enable, .enhancer_skip,
  .earpiece_fixed_0db, .earpiece_impedance_sel);
`default_nettype wire

// [vpc_master.sv]
`timescale 1ns/1ps
`default_nettype none
module vpc_master (
  // clock
  input wire logic clk_sys,
  // bus
  input wire logic sda_oe,
  output var logic scl,
  output var logic sda_m,
  output var logic acked
);
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
    acked = 1'h0;
  end
  task automatic hp();
    repeat (8) @(negedge clk_sys);
  endtask
  // one bit, data set while clock low
  task automatic bit_o(input logic b);
    sda_m = b;
    hp();
    scl = 1'h1;
    hp();
    acked = sda_oe;
    scl = 1'h0;
  endtask
  task automatic byte_o(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_o(v[i]);
    bit_o(1'h1);
  endtask
  task automatic send(input logic [7:0] a, input logic [7:0] d);
    sda_m = 1'h0;
    hp();
    scl = 1'h0;
    byte_o(a);
    byte_o(d);
    sda_m = 1'h0;
    hp();
    scl = 1'h1;
    hp();
    sda_m = 1'h1;
    hp();
  endtask
endmodule // vpc_master
`default_nettype wire

// [vpc_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module vpc_regs_tb;
  logic clk_sys, resetn, scl_in, sda_m, sda_in, sda_out, sda_oe, acked;
  logic supply_ok_in, iface_reset_n_in, standby_n_in, device_run, earpiece_on;
  logic supply_drop_reset_sel, nc_enable, nc_bypass, mic1_route, mic2_route;
  logic mic_average, path1_silence, path2_silence, output_lowpass_node_en;
  logic postamp_12db, speaker_silence, level_limit_high, limiter_enable;
  logic enhancer_skip, earpiece_fixed_0db;
  logic [3:0] preamp_gain;
  logic [2:0] earpiece_impedance_sel;
  int fail_count = 0;
  int num_checks = 0;
  assign sda_in = sda_m & ~sda_oe;
  vpc_regs uut (.clk_sys, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe, .supply_ok_in,
    .iface_reset_n_in, .standby_n_in, .device_run, .earpiece_on, .supply_drop_reset_sel,
    .nc_enable, .nc_bypass, .mic1_route, .mic2_route, .mic_average, .path1_silence,
    .path2_silence, .output_lowpass_node_en, .preamp_gain, .postamp_12db,
    .speaker_silence, .level_limit_high, .limiter_enable, .enhancer_skip,
    .earpiece_fixed_0db, .earpiece_impedance_sel);
  vpc_master m (.clk_sys, .sda_oe, .scl(scl_in), .sda_m, .acked);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [1:0] idx, input logic [4:0] d);
    m.send(8'hce, {1'h0, idx, d});
    chk({7'h0, m.acked}, 8'h01);
  endtask
  task automatic pin(input int w, input logic v);
    if (w == 0) supply_ok_in = v;
    else if (w == 1) standby_n_in = v;
    else iface_reset_n_in = v;
    repeat (10) @(negedge clk_sys);
  endtask
  function automatic logic [7:0] ep();
    return {speaker_silence, level_limit_high, enhancer_skip, earpiece_fixed_0db,
            limiter_enable, earpiece_impedance_sel};
  endfunction
  function automatic logic [7:0] mu();
    return {5'h0, nc_enable, path2_silence, path1_silence};
  endfunction
  task automatic t_power();
    chk(ep(), 8'h01);
    wr(2'h0, 5'h05);
    chk({6'h0, device_run, earpiece_on}, 8'h03);
    pin(1, 1'h0);
    chk({6'h0, device_run, earpiece_on}, 8'h00);
    pin(1, 1'h1);
    chk({6'h0, device_run, earpiece_on}, 8'h03);
  endtask
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      wr(2'h1, {i[1:0], 3'h0});
      chk({2'h0, nc_enable, nc_bypass, mic1_route, mic2_route, mic_average,
           output_lowpass_node_en}, {2'h0, i == 0, i != 0, i != 2, i != 1, i == 3,
           i == 0});
    end
  endtask
  task automatic t_mute();
    wr(2'h1, 5'h03);
    chk(mu(), 8'h04);
    wr(2'h1, 5'h05);
    chk(mu(), 8'h01);
    wr(2'h1, 5'h1e);
    chk(mu(), 8'h02);
  endtask
  task automatic t_gain();
    wr(2'h2, 5'h1a);
    chk({3'h0, postamp_12db, preamp_gain}, 8'h1a);
    wr(2'h2, 5'h05);
    chk({3'h0, postamp_12db, preamp_gain}, 8'h05);
  endtask
  task automatic t_ep();
    for (int c = 0; c < 4; c++) begin
      wr(2'h3, {3'h7, c[1:0]});
      chk(ep(), (c == 0) ? 8'hf1 : (c == 1) ? 8'hf2 : 8'hf4);
    end
    wr(2'h3, 5'h00);
    chk(ep(), 8'h09);
  endtask
  task automatic t_refuse();
    m.send(8'hcf, 8'h00);
    chk({6'h0, sda_out, m.acked}, 8'h00);
    m.send(8'h64, 8'h00);
    chk({6'h0, m.acked, device_run}, 8'h01);
  endtask
  task automatic t_supply();
    pin(0, 1'h0);
    pin(0, 1'h1);
    chk({3'h0, device_run, preamp_gain}, 8'h00);
    wr(2'h0, 5'h07);
    wr(2'h2, 5'h05);
    pin(0, 1'h0);
    pin(0, 1'h1);
    chk({2'h0, supply_drop_reset_sel, device_run, preamp_gain}, 8'h35);
  endtask
  task automatic t_ifrst();
    pin(2, 1'h0);
    pin(2, 1'h1);
    chk({7'h0, device_run}, 8'h00);
    wr(2'h0, 5'h05);
    chk({7'h0, device_run}, 8'h01);
  endtask
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
  initial begin
    resetn = 1'h0;
    supply_ok_in = 1'h1;
    iface_reset_n_in = 1'h1;
    standby_n_in = 1'h1;
    repeat (12) @(negedge clk_sys);
    resetn = 1'h1;
    repeat (2) @(negedge clk_sys);
    t_power();
    t_modes();
    t_mute();
    t_gain();
    t_ep();
    t_refuse();
    t_supply();
    t_ifrst();
    summarize();
  end
endmodule // vpc_regs_tb
`default_nettype wire
